// ==== sleep_wakeup_defines.vh ====
`ifndef SLEEP_WAKEUP_DEFINES_VH
`define SLEEP_WAKEUP_DEFINES_VH
// register offsets (own map, 8-bit data)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_INTCTL 4'h2
`define REG_WDT_CNT 4'h3
// control register fields
`define CTRL_WDT_EN 0
`define CTRL_XTAL_MODE 1
// status register fields
`define STAT_PD 3
`define STAT_TO 4
`define STAT_ASLEEP 0
`define STAT_OST_BUSY 1
// interrupt control fields
`define IC_GIE 7
`define IC_T0IE 5
`define IC_INTE 4
`define IC_RBIE 3
`define IC_T0IF 2
`define IC_INTF 1
`define IC_RBIF 0
// reset values
`define CTRL_RESET 8'h03
`define INTCTL_RESET 8'h00
// oscillator start-up delay in oscillator periods
`define OST_PERIODS 1024
// last value of the start-up counter, reached on the 1023rd edge; the 1024th edge ends the wait
`define OST_LAST 11'h3ff
// interrupt vector
`define INT_VECTOR 13'h0004
// watchdog count width and terminal value
`define WDT_TERMINAL 16'hffff
`endif

// ==== sync2.v ====
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pins entering the mclk domain
module sync2 (
	// clock and reset
	input wire mclk,
	input wire sys_rst,
	// asynchronous input and synchronised output
	input wire din,
	output reg dout
);
	reg stage1; // first stage, read only by the second stage

	// capture then re-time
	always @(posedge mclk) begin
		if (sys_rst) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule
`default_nettype wire

// ==== sleep_wakeup_control.v ====
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wakeup_defines.vh"
module sleep_wakeup_control (
	// clock and reset
	input wire mclk,
	input wire sys_rst,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// core sequencer
	input wire sleep_exec,
	input wire [12:0] pc_now,
	input wire clrwdt_exec,
	input wire timer_overflow,
	output reg core_clk_run,
	output reg [12:0] prefetch_addr,
	output reg prefetch_req,
	output reg vector_req,
	output reg [12:0] vector_addr,
	output reg device_reset,
	// pins (two-flop synchronised)
	input wire master_clear_pin_n,
	input wire external_interrupt_pin,
	input wire port_change_pin,
	// oscillator and watchdog clock tick
	input wire wdt_tick,
	input wire osc_tick,
	output reg osc_driver_en,
	// io hold
	input wire [7:0] io_out_in,
	input wire [7:0] io_oe_n_in,
	output reg [7:0] io_out,
	output reg [7:0] io_oe_n,
	// master clear pin drive (never driven low)
	output wire master_clear_out,
	output wire master_clear_oe_n
);
	// states, one-hot
	localparam [3:0] st_run = 4'b0001;
	localparam [3:0] st_sleep = 4'b0010;
	localparam [3:0] st_ost = 4'b0100;
	localparam [3:0] st_resume = 4'b1000;

	reg [3:0] state; // sequencer state
	reg [3:0] next_state; // next sequencer state
	reg [7:0] ctrl; // watchdog enable and oscillator mode
	reg [7:0] intctl; // interrupt enables and flags
	reg pd_flag; // power-down flag, 1 after power-up
	reg to_flag; // timeout flag, 1 after power-up
	reg [15:0] wdt_cnt; // watchdog count
	reg [10:0] ost_cnt; // start-up period counter
	reg wake_src_wdt; // latched cause: watchdog
	reg wake_src_int; // latched cause: interrupt
	reg master_clear_pin_n_s; // synchronised master clear, low active
	reg master_clear_pin_n_q; // previous master clear level
	reg ext_int_s; // synchronised external interrupt
	reg ext_int_q; // previous external interrupt level
	reg port_chg_s; // synchronised port change
	reg port_chg_q; // previous port change level
	wire wdt_s; // synchronised watchdog tick
	wire osc_s; // synchronised oscillator tick
	reg wdt_q; // previous watchdog tick
	reg osc_q; // previous oscillator tick
	wire wdt_edge; // watchdog oscillator edge
	wire osc_edge; // oscillator period edge
	wire int_edge; // rising edge on external interrupt
	wire chg_edge; // rising edge on port change input
	wire master_clear_pin_fall; // master clear asserted
	wire wdt_timeout; // watchdog reached its terminal count
	wire int_pending; // either enabled pin interrupt with flag set
	wire wdt_en; // watchdog enabled
	wire xtal_mode; // crystal oscillator selected

	// pin synchronisers; every synchroniser resets low, so master clear is
	// inverted on the way in: its idle level then matches the reset value
	// and no false master clear edge follows reset
	wire master_clear_pin_sync; // master clear asserted, high active
	wire int_sync;
	wire chg_sync;
	sync2 u_sync_master_clear_pin (.mclk(mclk), .sys_rst(sys_rst),
		.din(~master_clear_pin_n), .dout(master_clear_pin_sync));
	sync2 u_sync_int (.mclk(mclk), .sys_rst(sys_rst),
		.din(external_interrupt_pin), .dout(int_sync));
	sync2 u_sync_chg (.mclk(mclk), .sys_rst(sys_rst),
		.din(port_change_pin), .dout(chg_sync));
	sync2 u_sync_wdt (.mclk(mclk), .sys_rst(sys_rst),
		.din(wdt_tick), .dout(wdt_s));
	sync2 u_sync_osc (.mclk(mclk), .sys_rst(sys_rst),
		.din(osc_tick), .dout(osc_s));

	// master clear is only ever sensed, never driven
	assign master_clear_out = 1'b1;
	assign master_clear_oe_n = 1'b1;

	assign wdt_en = ctrl[`CTRL_WDT_EN];
	assign xtal_mode = ctrl[`CTRL_XTAL_MODE];
	assign wdt_edge = wdt_s & ~wdt_q;
	assign osc_edge = osc_s & ~osc_q;
	assign int_edge = ext_int_s & ~ext_int_q;
	assign chg_edge = port_chg_s & ~port_chg_q;
	assign master_clear_pin_fall = ~master_clear_pin_n_s & master_clear_pin_n_q;
	assign wdt_timeout = wdt_en & wdt_edge & (wdt_cnt == `WDT_TERMINAL);
	// only pin interrupts count; timer overflow is excluded
	assign int_pending =
		(intctl[`IC_INTE] & intctl[`IC_INTF]) |
		(intctl[`IC_RBIE] & intctl[`IC_RBIF]);

	// edge history registers
	always @(posedge mclk) begin
		if (sys_rst) begin
			master_clear_pin_n_s <= 1'b1;
			master_clear_pin_n_q <= 1'b1;
			ext_int_s <= 1'b0;
			ext_int_q <= 1'b0;
			port_chg_s <= 1'b0;
			port_chg_q <= 1'b0;
			wdt_q <= 1'b0;
			osc_q <= 1'b0;
		end else begin
			master_clear_pin_n_s <= ~master_clear_pin_sync;
			master_clear_pin_n_q <= master_clear_pin_n_s;
			ext_int_s <= int_sync;
			ext_int_q <= ext_int_s;
			port_chg_s <= chg_sync;
			port_chg_q <= port_chg_s;
			wdt_q <= wdt_s;
			osc_q <= osc_s;
		end
	end

	// next-state logic
	always @* begin
		next_state = state;
		case (state)
			st_run: begin
				if (sleep_exec) begin
					next_state = st_sleep;
				end
			end
			st_sleep: begin
				if (master_clear_pin_fall) begin
					next_state = st_run;
				end else if (int_pending) begin
					next_state = xtal_mode ? st_ost : st_resume;
				end else if (wdt_timeout) begin
					next_state = xtal_mode ? st_ost : st_resume;
				end
			end
			st_ost: begin
				if (master_clear_pin_fall) begin
					next_state = st_run;
				end else if (osc_edge && ost_cnt == `OST_LAST) begin
					// counts 0 to 1023, so this is the 1024th edge
					next_state = st_resume;
				end
			end
			st_resume: begin
				next_state = st_run;
			end
			default: begin
				next_state = st_run;
			end
		endcase
	end

	// state register, wake cause latch and start-up counter
	always @(posedge mclk) begin
		if (sys_rst) begin
			state <= st_run;
			ost_cnt <= 11'h000;
			wake_src_wdt <= 1'b0;
			wake_src_int <= 1'b0;
		end else begin
			state <= next_state;
			// the cause is kept through the start-up delay so that the
			// resume cycle still knows whether to request the vector
			if (state == st_sleep) begin
				ost_cnt <= 11'h000;
				// cause latched on mclk, core clock stopped
				if (int_pending) begin
					wake_src_int <= 1'b1;
					wake_src_wdt <= 1'b0;
				end else if (wdt_timeout) begin
					wake_src_wdt <= 1'b1;
					wake_src_int <= 1'b0;
				end
			end else if (state == st_ost && osc_edge) begin
				ost_cnt <= ost_cnt + 11'h001;
			end else if (state == st_run) begin
				wake_src_wdt <= 1'b0;
				wake_src_int <= 1'b0;
			end
		end
	end

	// core control outputs
	always @(posedge mclk) begin
		if (sys_rst) begin
			core_clk_run <= 1'b1;
			osc_driver_en <= 1'b1;
			prefetch_req <= 1'b0;
			prefetch_addr <= 13'h0000;
			vector_req <= 1'b0;
			vector_addr <= 13'h0000;
			device_reset <= 1'b0;
		end else begin
			// core restarts after start-up delay in crystal mode only; rc wake restarts after the one resume cycle, master clear at once
			core_clk_run <= (next_state == st_run);
			osc_driver_en <= (next_state != st_sleep);
			// the word after the power-down instruction is fetched now
			prefetch_req <= (state == st_run) && sleep_exec;
			if (state == st_run && sleep_exec) begin
				prefetch_addr <= pc_now + 13'h0001;
			end
			// vector after the prefetched instruction if global set
			vector_req <= (state == st_resume) && wake_src_int &&
				intctl[`IC_GIE];
			vector_addr <= `INT_VECTOR;
			// master clear: full reset; watchdog wake: no reset
			device_reset <= ((state == st_sleep) ||
				(state == st_ost)) && master_clear_pin_fall;
		end
	end

	// pin hold: sample in run, freeze while asleep
	always @(posedge mclk) begin
		if (sys_rst) begin
			io_out <= 8'h00;
			io_oe_n <= 8'hff;
		end else if (state == st_run) begin
			io_out <= io_out_in;
			io_oe_n <= io_oe_n_in;
		end
	end

	// watchdog count
	always @(posedge mclk) begin
		if (sys_rst) begin
			wdt_cnt <= 16'h0000;
		end else if (state == st_run && sleep_exec) begin
			wdt_cnt <= 16'h0000;
		end else if (state != st_sleep && next_state == st_sleep) begin
			wdt_cnt <= 16'h0000;
		end else if (state == st_sleep && next_state != st_sleep) begin
			wdt_cnt <= 16'h0000;
		end else if (clrwdt_exec || (wdt_edge && wdt_timeout)) begin
			wdt_cnt <= 16'h0000;
		end else if (wdt_en && wdt_edge) begin
			wdt_cnt <= wdt_cnt + 16'h0001;
		end
	end

	// status flags; sys_rst acts as power-up
	always @(posedge mclk) begin
		if (sys_rst) begin
			pd_flag <= 1'b1;
			to_flag <= 1'b1;
		end else if (state == st_run && sleep_exec) begin
			pd_flag <= 1'b0;
			to_flag <= 1'b1;
		end else if (state == st_sleep && !int_pending &&
			!master_clear_pin_fall && wdt_timeout) begin
			to_flag <= 1'b0;
		end else if (state == st_run && wdt_timeout) begin
			to_flag <= 1'b0;
		end
	end

	// control and interrupt control registers
	always @(posedge mclk) begin
		if (sys_rst) begin
			ctrl <= `CTRL_RESET;
			intctl <= `INTCTL_RESET;
		end else begin
			if (reg_wr && reg_addr == `REG_CTRL) begin
				ctrl <= reg_wdata;
			end
			if (reg_wr && reg_addr == `REG_INTCTL) begin
				intctl <= reg_wdata;
			end
			// hardware set wins over software clear
			if (int_edge) begin
				intctl[`IC_INTF] <= 1'b1;
			end
			if (chg_edge) begin
				intctl[`IC_RBIF] <= 1'b1;
			end
			if (timer_overflow && state == st_run) begin
				intctl[`IC_T0IF] <= 1'b1;
			end
		end
	end

	// read data, one cycle after the strobe
	always @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `REG_CTRL) begin
				reg_rdata <= ctrl;
			end else if (reg_addr == `REG_STATUS) begin
				reg_rdata <= {3'h0, to_flag, pd_flag, 1'b0,
					state == st_ost, state != st_run};
			end else if (reg_addr == `REG_INTCTL) begin
				reg_rdata <= intctl;
			end else if (reg_addr == `REG_WDT_CNT) begin
				reg_rdata <= wdt_cnt[15:8];
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== swc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks of power-down entry and resume
module swc_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// core side
	input wire logic sleep_exec,
	input wire logic [12:0] pc_now,
	input wire logic core_clk_run,
	input wire logic osc_driver_en,
	input wire logic prefetch_req,
	input wire logic [12:0] prefetch_addr,
	input wire logic vector_req,
	input wire logic [12:0] vector_addr,
	// pins
	input wire logic [7:0] io_out,
	input wire logic [7:0] io_oe_n,
	input wire logic master_clear_out,
	input wire logic master_clear_oe_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	AST_PREFETCH: assert property (sleep_exec && core_clk_run |=>
		prefetch_req && prefetch_addr == $past(pc_now) + 13'h0001)
		else $error("prefetch address wrong");
	AST_CLK_STOP: assert property (sleep_exec && core_clk_run |=>
		!core_clk_run && !osc_driver_en) else $error("clock kept running");
	AST_ONLY_SLEEP: assert property ($fell(core_clk_run) |->
		$past(sleep_exec)) else $error("sleep without instruction");
	AST_PREF_CAUSE: assert property (prefetch_req |->
		$past(sleep_exec)) else $error("stray prefetch");
	AST_IO_HOLD: assert property (!core_clk_run && !$past(core_clk_run)
		|-> $stable(io_out) && $stable(io_oe_n)) else $error("pins moved");
	AST_MASTER_CLEAR_PIN: assert property (master_clear_oe_n && master_clear_out)
		else $error("master clear driven");
	AST_VECTOR: assert property (vector_req |->
		vector_addr == 13'h0004 && !$past(vector_req))
		else $error("bad vector request");
	AST_OSC_RUN: assert property (core_clk_run |-> osc_driver_en)
		else $error("core runs without oscillator");
endmodule
bind sleep_wakeup_control swc_chk i_swc_chk (.mclk, .sys_rst, .sleep_exec,
	.pc_now, .core_clk_run, .osc_driver_en, .prefetch_req, .prefetch_addr,
	.vector_req, .vector_addr, .io_out, .io_oe_n, .master_clear_out,
	.master_clear_oe_n);
`default_nettype wire

// ==== core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// core sequencer and the two oscillators
module core_model (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// sequencer view
	input wire logic core_clk_run,
	input wire logic osc_driver_en,
	input wire logic vector_req,
	input wire logic [12:0] vector_addr,
	output logic [12:0] pc_now,
	// oscillator ticks
	output logic osc_tick,
	output wire logic wdt_tick
);
	logic [1:0] wdt_div; // slow rc oscillator divider
	// pc moves only while the core clock runs; crystal toggles while driven
	always @(posedge mclk) begin
		if (sys_rst) begin
			pc_now <= 13'h0010;
			osc_tick <= 1'b0;
			wdt_div <= 2'h0;
		end else begin
			// the crystal stands still while its driver is off
			if (osc_driver_en)
				osc_tick <= ~osc_tick;
			wdt_div <= wdt_div + 2'h1;
			if (vector_req)
				pc_now <= vector_addr;
			else if (core_clk_run)
				pc_now <= pc_now + 13'h0001;
		end
	end
	assign wdt_tick = wdt_div[1];
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wakeup_defines.vh"
// power-down entry and wake scenarios
module tb;
	logic mclk, sys_rst, reg_wr, reg_rd, sleep_exec, clrwdt_exec;
	logic timer_overflow, core_clk_run, prefetch_req, vector_req;
	logic device_reset, master_clear_pin_n, external_interrupt_pin;
	logic port_change_pin, wdt_tick, osc_tick, osc_driver_en;
	logic master_clear_out, master_clear_oe_n, seen_vec;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, io_out_in, io_oe_n_in, io_out, io_oe_n;
	logic [12:0] pc_now, prefetch_addr, vector_addr;
	int error_cnt, check_count, n;
	sleep_wakeup_control i_sleep_wakeup_control (.mclk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .pc_now,
		.clrwdt_exec, .timer_overflow, .core_clk_run, .prefetch_addr,
		.prefetch_req, .vector_req, .vector_addr, .device_reset,
		.master_clear_pin_n, .external_interrupt_pin, .port_change_pin,
		.wdt_tick, .osc_tick, .osc_driver_en, .io_out_in, .io_oe_n_in,
		.io_out, .io_oe_n, .master_clear_out, .master_clear_oe_n);
	core_model i_core_model (.mclk, .sys_rst, .core_clk_run, .osc_driver_en,
		.vector_req, .vector_addr, .pc_now, .osc_tick, .wdt_tick);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// remembers any vector request since the last power-down entry
	always @(posedge mclk) begin
		if (sys_rst || sleep_exec) begin
			seen_vec <= 1'b0;
		end else if (vector_req === 1'b1) begin
			seen_vec <= 1'b1;
		end
	end
	task chk(input string what, input logic [12:0] exp, act);
		check_count++;
		if (act !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, act);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data is judged in the cycle after the strobe
	task rd(string what, logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(what, {5'h00, e}, {5'h00, reg_rdata & m});
	endtask
	task enter_sleep;
		@(posedge mclk);
		// the word after the power-down instruction is a no-operation
		sleep_exec <= 1'b1;
		@(posedge mclk);
		sleep_exec <= 1'b0;
		#1;
	endtask
	// counts cycles until the core clock restarts
	task wait_run(input int lim);
		n = 0;
		while (core_clk_run !== 1'b1 && n < lim) begin
			@(posedge mclk);
			#1 n++;
		end
	endtask
	task t_reset;
		rd("status", `REG_STATUS, 8'h18);
		rd("ctrl", `REG_CTRL, `CTRL_RESET);
		rd("intctl", `REG_INTCTL, `INTCTL_RESET);
		rd("unmapped", 4'h9, 8'h00);
		$display("reset test done");
	endtask
	// pin interrupt, global enable off, crystal start-up delay
	task t_int_xtal;
		wr(`REG_INTCTL, 8'h30);
		io_out_in <= 8'ha5;
		io_oe_n_in <= 8'h0f;
		// let the watchdog pass 255 so that its clear on entry shows
		repeat (1100) @(posedge mclk);
		enter_sleep;
		chk("clk run", 13'h0000, {12'h000, core_clk_run});
		@(posedge mclk);
		io_out_in <= 8'h5a;
		io_oe_n_in <= 8'hf0;
		rd("sleep status", `REG_STATUS, 8'h11);
		rd("wdt count", `REG_WDT_CNT, 8'h00);
		chk("io held", 13'h00a5, {5'h00, io_out});
		chk("oe held", 13'h000f, {5'h00, io_oe_n});
		@(posedge mclk);
		timer_overflow <= 1'b1;
		port_change_pin <= 1'b1;
		@(posedge mclk);
		timer_overflow <= 1'b0;
		repeat (12) @(posedge mclk);
		#1 chk("no wake", 13'h0000, {12'h000, core_clk_run});
		@(posedge mclk);
		external_interrupt_pin <= 1'b1;
		wait_run(3000);
		chk("ost wait", 13'h0001, {12'h000, n >= 2048 && n < 3000});
		rd("int flag", `REG_INTCTL, 8'h32, 8'hfe);
		rd("woke status", `REG_STATUS, 8'h10);
		chk("no vector", 13'h0000, {12'h000, seen_vec});
		$display("pin wake test done");
	endtask
	// flag pending at entry, global enable on, rc mode
	task t_pending_rc;
		wr(`REG_CTRL, 8'h01);
		wr(`REG_INTCTL, 8'hb2);
		external_interrupt_pin <= 1'b0;
		enter_sleep;
		wait_run(20);
		chk("fast wake", 13'h0001, {12'h000, n < 20});
		repeat (3) @(posedge mclk);
		#1 chk("vectored", 13'h0001, {12'h000, seen_vec});
		$display("pending wake test done");
	endtask
	// master clear during power-down resets the device
	task t_master_clear_pin;
		wr(`REG_INTCTL, 8'h00);
		wr(`REG_CTRL, 8'h03);
		enter_sleep;
		@(posedge mclk);
		master_clear_pin_n <= 1'b0;
		n = 0;
		while (device_reset !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1 n++;
		end
		chk("master_clear_pin reset", 13'h0001, {12'h000, n < 20});
		@(posedge mclk);
		master_clear_pin_n <= 1'b1;
		repeat (10) @(posedge mclk);
		rd("master_clear_pin status", `REG_STATUS, 8'h10);
		$display("master clear test done");
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, sleep_exec} = '0;
		{clrwdt_exec, timer_overflow, external_interrupt_pin} = '0;
		{port_change_pin, io_out_in} = '0;
		io_oe_n_in = 8'hff;
		master_clear_pin_n = 1'b1;
		sys_rst = 1'b1;
		error_cnt = 0;
		check_count = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset;
		t_int_xtal;
		t_pending_rc;
		t_master_clear_pin;
		tally_and_finish;
	end
	// hang guard, well past the longest start-up wait
	initial begin
		#60000;
		error_cnt++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
